// File: ntm_pkg.sv
// package of constants and types for the noise test mode control block
//==============================================================================
// Functional notes
// - test register is a custom control register, machine privilege only
// - bit 31 enables test mode; other bits are implementation specific
// - with test mode on, polled entropy never reports delivered state or data
// - test mode forces self-test state unless already in fatal state
// - clearing test mode zeroizes state and reruns self-test before leaving it
// - pending and delivered states are unreachable during test mode
// - when register absent, reads give zero and writes are dropped
// - present but test off: reads give fixed nonzero value, never noise
// - no test feature alters the delivered entropy output
// - permanent error enters fatal state; non-fatal errors rerun self-test
// - health-test state cleared to zero on system reset
//==============================================================================
package ntm_pkg;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;
    localparam int TEST_EN_BIT = 31;
    localparam logic TEST_EN_RESET = 1'b0;
    localparam logic [31:0] IDLE_READ_VALUE = 32'h0000_0001;
    localparam logic [31:0] ABSENT_READ_VALUE = 32'h0000_0000;
    localparam int ENTROPY_W = 16;
    localparam int RAW_W = 16;
    localparam int REP_CUTOFF_DEF = 32;
    localparam int SELFTEST_LEN_DEF = 64;
    localparam int CNT_W = 8;
    // status codes reported on the polled entropy port
    localparam logic [1:0] OPST_SELF_TEST = 2'h0;
    localparam logic [1:0] OPST_PENDING = 2'h1;
    localparam logic [1:0] OPST_DELIVERED = 2'h2;
    localparam logic [1:0] OPST_FATAL = 2'h3;
    typedef enum {SRC_SELF_TEST, SRC_PENDING, SRC_DELIVERED, SRC_FATAL} ntm_src_e;
endpackage : ntm_pkg

// File: ntm_noise_test_ctrl.sv
// noise test mode control: test register, entropy source states and health test
`timescale 1ns/10ps
module ntm_noise_test_ctrl #(
    parameter int REP_CUTOFF = ntm_pkg::REP_CUTOFF_DEF,
    parameter int SELFTEST_LEN = ntm_pkg::SELFTEST_LEN_DEF,
    parameter bit REG_PRESENT = 1'b1
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic NOISE_BIT,
    input wire logic FATAL_ERR,
    input wire logic CSR_REQ,
    input wire logic CSR_WE,
    input wire logic [1:0] CSR_PRIV,
    input wire logic [31:0] CSR_WDATA,
    output logic CSR_ACK,
    output logic CSR_ILLEGAL,
    output logic [31:0] CSR_RDATA,
    input wire logic SEED_REQ,
    output logic SEED_ACK,
    output logic [1:0] SEED_OPST,
    output logic [ntm_pkg::ENTROPY_W-1:0] SEED_ENTROPY,
    output logic TEST_MODE
);
    //==========================================================================
    // input synchronisers
    //==========================================================================
    logic [1:0] s1_q, s2_q, s3_q;
    logic [1:0] s1_d, s2_d, s3_d;

    always_comb begin
        s1_d = {FATAL_ERR, NOISE_BIT};
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
            s3_q <= 2'h0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    // a bit counts only when the last two stages agree
    logic sample_ok;
    logic sample_bit;
    logic fatal_in;
    assign sample_ok = (s2_q[0] == s3_q[0]);
    assign sample_bit = s3_q[0];
    assign fatal_in = s2_q[1] & s3_q[1];

    //==========================================================================
    // source state, health test, accumulator, test register
    //==========================================================================
    ntm_pkg::ntm_src_e state_q, state_d;
    logic test_q, test_d;
    logic last_bit_q, last_bit_d;
    logic [ntm_pkg::CNT_W-1:0] rep_cnt_q, rep_cnt_d;
    logic [ntm_pkg::CNT_W-1:0] st_cnt_q, st_cnt_d;
    logic [ntm_pkg::ENTROPY_W-1:0] acc_q, acc_d;
    logic [4:0] acc_cnt_q, acc_cnt_d;
    logic [ntm_pkg::RAW_W-1:0] raw_q, raw_d;
    logic alarm;
    logic csr_ok;
    logic seed_take;

    assign csr_ok = CSR_REQ && (CSR_PRIV == ntm_pkg::PRIV_MACHINE);
    assign seed_take = SEED_REQ && (state_q == ntm_pkg::SRC_DELIVERED);
    // repetition count at or past its cutoff on a repeated sample
    assign alarm = sample_ok && (sample_bit == last_bit_q)
        && (rep_cnt_q >= ntm_pkg::CNT_W'(REP_CUTOFF - 1));

    always_comb begin
        state_d = state_q;
        test_d = test_q;
        last_bit_d = last_bit_q;
        rep_cnt_d = rep_cnt_q;
        st_cnt_d = st_cnt_q;
        acc_d = acc_q;
        acc_cnt_d = acc_cnt_q;
        raw_d = raw_q;
        // low privilege never reaches the register
        if (csr_ok && CSR_WE && REG_PRESENT) begin
            test_d = CSR_WDATA[ntm_pkg::TEST_EN_BIT];
        end
        if (sample_ok) begin
            raw_d = {raw_q[ntm_pkg::RAW_W-2:0], sample_bit};
            last_bit_d = sample_bit;
            // saturates, so a stuck source keeps alarming and never delivers
            if (sample_bit != last_bit_q) begin
                rep_cnt_d = '0;
            end else if (rep_cnt_q != '1) begin
                rep_cnt_d = rep_cnt_q + 1'b1;
            end
        end
        case (state_q)
            ntm_pkg::SRC_SELF_TEST: begin
                if (sample_ok) begin
                    st_cnt_d = st_cnt_q + 1'b1;
                end
                if (st_cnt_q == ntm_pkg::CNT_W'(SELFTEST_LEN - 1) && sample_ok) begin
                    state_d = ntm_pkg::SRC_PENDING;
                    st_cnt_d = '0;
                end
            end
            ntm_pkg::SRC_PENDING: begin
                if (sample_ok) begin
                    acc_d = {acc_q[ntm_pkg::ENTROPY_W-2:0], sample_bit};
                    acc_cnt_d = acc_cnt_q + 1'b1;
                end
                if (sample_ok && acc_cnt_q == 5'(ntm_pkg::ENTROPY_W - 1)) begin
                    state_d = ntm_pkg::SRC_DELIVERED;
                end
            end
            ntm_pkg::SRC_DELIVERED: begin
                // word is wiped once handed out, never reused
                if (seed_take) begin
                    acc_d = '0;
                    acc_cnt_d = '0;
                    state_d = ntm_pkg::SRC_PENDING;
                end
            end
            ntm_pkg::SRC_FATAL: begin
                state_d = ntm_pkg::SRC_FATAL;
            end
            default: begin
                state_d = ntm_pkg::SRC_FATAL;
            end
        endcase
        if (alarm && state_q != ntm_pkg::SRC_FATAL) begin
            state_d = ntm_pkg::SRC_SELF_TEST;
            st_cnt_d = '0;
            acc_d = '0;
            acc_cnt_d = '0;
        end
        // held zeroized for all of test mode, so the self-test after it starts clean
        if (test_q && state_q != ntm_pkg::SRC_FATAL) begin
            state_d = ntm_pkg::SRC_SELF_TEST;
            st_cnt_d = '0;
            rep_cnt_d = '0;
            acc_d = '0;
            acc_cnt_d = '0;
        end
        if (fatal_in || state_q == ntm_pkg::SRC_FATAL) begin
            state_d = ntm_pkg::SRC_FATAL;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ntm_pkg::SRC_SELF_TEST;
            test_q <= ntm_pkg::TEST_EN_RESET;
            last_bit_q <= 1'b0;
            rep_cnt_q <= '0;
            st_cnt_q <= '0;
            acc_q <= '0;
            acc_cnt_q <= '0;
            raw_q <= '0;
        end else begin
            state_q <= state_d;
            test_q <= test_d;
            last_bit_q <= last_bit_d;
            rep_cnt_q <= rep_cnt_d;
            st_cnt_q <= st_cnt_d;
            acc_q <= acc_d;
            acc_cnt_q <= acc_cnt_d;
            raw_q <= raw_d;
        end
    end

    //==========================================================================
    // answers on the register and polled entropy ports
    //==========================================================================
    logic csr_ack_q, csr_ack_d;
    logic csr_ill_q, csr_ill_d;
    logic [31:0] csr_rdata_q, csr_rdata_d;
    logic seed_ack_q, seed_ack_d;
    logic [1:0] seed_opst_q, seed_opst_d;
    logic [ntm_pkg::ENTROPY_W-1:0] seed_ent_q, seed_ent_d;
    logic test_out_q, test_out_d;

    always_comb begin
        csr_ack_d = CSR_REQ;
        csr_ill_d = CSR_REQ && !csr_ok;
        csr_rdata_d = '0;
        if (csr_ok) begin
            if (!REG_PRESENT) begin
                csr_rdata_d = ntm_pkg::ABSENT_READ_VALUE;
            end else if (test_q) begin
                // raw samples only while test mode is on
                csr_rdata_d = {1'b1, 15'h0000, raw_q};
            end else begin
                csr_rdata_d = ntm_pkg::IDLE_READ_VALUE;
            end
        end
        seed_ack_d = SEED_REQ;
        seed_opst_d = ntm_pkg::OPST_SELF_TEST;
        seed_ent_d = '0;
        case (state_q)
            ntm_pkg::SRC_SELF_TEST: seed_opst_d = ntm_pkg::OPST_SELF_TEST;
            ntm_pkg::SRC_PENDING: seed_opst_d = ntm_pkg::OPST_PENDING;
            ntm_pkg::SRC_DELIVERED: begin
                // entropy path has no test tap, only the gate below
                if (!test_q) begin
                    seed_opst_d = ntm_pkg::OPST_DELIVERED;
                    seed_ent_d = acc_q;
                end
            end
            ntm_pkg::SRC_FATAL: seed_opst_d = ntm_pkg::OPST_FATAL;
            default: seed_opst_d = ntm_pkg::OPST_FATAL;
        endcase
        test_out_d = test_q;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            csr_ack_q <= 1'b0;
            csr_ill_q <= 1'b0;
            csr_rdata_q <= '0;
            seed_ack_q <= 1'b0;
            seed_opst_q <= ntm_pkg::OPST_SELF_TEST;
            seed_ent_q <= '0;
            test_out_q <= 1'b0;
        end else begin
            csr_ack_q <= csr_ack_d;
            csr_ill_q <= csr_ill_d;
            csr_rdata_q <= csr_rdata_d;
            seed_ack_q <= seed_ack_d;
            seed_opst_q <= seed_opst_d;
            seed_ent_q <= seed_ent_d;
            test_out_q <= test_out_d;
        end
    end

    assign CSR_ACK = csr_ack_q;
    assign CSR_ILLEGAL = csr_ill_q;
    assign CSR_RDATA = csr_rdata_q;
    assign SEED_ACK = seed_ack_q;
    assign SEED_OPST = seed_opst_q;
    assign SEED_ENTROPY = seed_ent_q;
    assign TEST_MODE = test_out_q;
endmodule : ntm_noise_test_ctrl

// File: ntm_noise_test_ctrl_monitor.sv
// port timing checker for the noise test mode control block
`timescale 1ns/10ps
module ntm_noise_test_ctrl_monitor #(
    parameter bit REG_PRESENT = 1'b1
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic CSR_REQ,
    input wire logic CSR_WE,
    input wire logic [1:0] CSR_PRIV,
    input wire logic [31:0] CSR_WDATA,
    input wire logic CSR_ACK,
    input wire logic CSR_ILLEGAL,
    input wire logic [31:0] CSR_RDATA,
    input wire logic SEED_REQ,
    input wire logic SEED_ACK,
    input wire logic [1:0] SEED_OPST,
    input wire logic [15:0] SEED_ENTROPY,
    input wire logic TEST_MODE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    //==========================================================
    // sequences
    sequence m_rd_s; CSR_REQ && !CSR_WE && CSR_PRIV == ntm_pkg::PRIV_MACHINE; endsequence
    // a write just before would leave the level port one cycle stale
    sequence quiet_rd_s; !(CSR_REQ && CSR_WE) ##1 m_rd_s; endsequence
    //==========================================================
    // assertions
    csr_ack_a: assert property (CSR_REQ |=> CSR_ACK) else $error("no register answer");
    low_priv_a: assert property (CSR_REQ && CSR_PRIV != ntm_pkg::PRIV_MACHINE |=> CSR_ILLEGAL && CSR_RDATA == 0)
        else $error("low privilege access not refused");
    test_write_a: assert property (CSR_REQ && CSR_WE && CSR_PRIV == ntm_pkg::PRIV_MACHINE |=> ##1
        TEST_MODE == (REG_PRESENT && $past(CSR_WDATA[ntm_pkg::TEST_EN_BIT], 2))) else $error("test enable wrong");
    seed_ack_a: assert property (SEED_REQ |=> SEED_ACK) else $error("no entropy answer");
    test_hold_a: assert property (SEED_ACK && TEST_MODE && $past(TEST_MODE) |-> SEED_ENTROPY == 0 &&
        SEED_OPST != ntm_pkg::OPST_DELIVERED && SEED_OPST != ntm_pkg::OPST_PENDING) else $error("entropy in test");
    entropy_gate_a: assert property (SEED_ACK && SEED_OPST != ntm_pkg::OPST_DELIVERED |-> SEED_ENTROPY == 0)
        else $error("entropy without delivery");
    idle_read_a: assert property (quiet_rd_s ##0 !TEST_MODE |=> CSR_RDATA ==
        (REG_PRESENT ? ntm_pkg::IDLE_READ_VALUE : ntm_pkg::ABSENT_READ_VALUE)) else $error("idle read wrong");
    test_read_a: assert property (quiet_rd_s ##0 TEST_MODE |=> CSR_RDATA[31] == REG_PRESENT)
        else $error("test read lacks enable");
endmodule : ntm_noise_test_ctrl_monitor
bind ntm_noise_test_ctrl ntm_noise_test_ctrl_monitor #(.REG_PRESENT(REG_PRESENT)) mon_u (.SYS_CLK(SYS_CLK),
    .ARST_N(ARST_N), .CSR_REQ(CSR_REQ), .CSR_WE(CSR_WE), .CSR_PRIV(CSR_PRIV), .CSR_WDATA(CSR_WDATA),
    .CSR_ACK(CSR_ACK), .CSR_ILLEGAL(CSR_ILLEGAL), .CSR_RDATA(CSR_RDATA), .SEED_REQ(SEED_REQ),
    .SEED_ACK(SEED_ACK), .SEED_OPST(SEED_OPST), .SEED_ENTROPY(SEED_ENTROPY), .TEST_MODE(TEST_MODE));

// File: ntm_noise_test_ctrl_test.sv
// self-checking bench for the noise test mode control block
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("unexpected %0t %h %h", $time, a, b); end end
module ntm_noise_test_ctrl_test;
    logic clk = 1'b0, arst_n = 1'b0, noise = 1'b0, fatal = 1'b0, stuck = 1'b0;
    logic req = 1'b0, we = 1'b0, seed_req = 1'b0, ack, ill, seed_ack, test_mode, r_ill;
    logic [1:0] priv = 2'h3, opst, r_st;
    logic [31:0] wdata = 32'h0000_0000, rdata, r_rd;
    logic [15:0] ent, r_ent;
    int n_errors = 0, num_checks = 0, ph = 0;
    always #2 clk = ~clk;
    // noise held two cycles per value, so the samples that count alternate and never repeat
    always @(posedge clk) begin
        #1;
        ph++;
        if (!stuck && ph % 2 == 0) noise = ~noise;
    end
    ntm_noise_test_ctrl #(.REP_CUTOFF(4), .SELFTEST_LEN(8), .REG_PRESENT(1'b1)) dut_u (.SYS_CLK(clk),
        .ARST_N(arst_n), .NOISE_BIT(noise), .FATAL_ERR(fatal), .CSR_REQ(req), .CSR_WE(we), .CSR_PRIV(priv),
        .CSR_WDATA(wdata), .CSR_ACK(ack), .CSR_ILLEGAL(ill), .CSR_RDATA(rdata), .SEED_REQ(seed_req),
        .SEED_ACK(seed_ack), .SEED_OPST(opst), .SEED_ENTROPY(ent), .TEST_MODE(test_mode));
    //==========================================================
    // bus tasks
    task automatic step(); @(posedge clk); #1; endtask : step
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic csr(input logic w, input logic [1:0] p, input logic [31:0] d);
        we = w;
        priv = p;
        wdata = d;
        req = 1'b1;
        step();
        // answer stands for this one cycle only
        `CHK(ack, 1'b1)
        r_rd = rdata;
        r_ill = ill;
        req = 1'b0;
        step();
    endtask : csr
    task automatic poll();
        seed_req = 1'b1;
        step();
        `CHK(seed_ack, 1'b1)
        r_st = opst;
        r_ent = ent;
        seed_req = 1'b0;
        step();
    endtask : poll
    task automatic wait_st(input logic [1:0] s);
        for (int i = 0; i < 100; i++) begin
            poll();
            if (r_st === s) return;
        end
        n_errors++;
        end_of_test();
    endtask : wait_st
    //==========================================================
    // scenarios
    task automatic t_reset();
        `CHK({test_mode, opst}, 3'h0)
        csr(1'b0, ntm_pkg::PRIV_MACHINE, 32'h0000_0000);
        `CHK(r_rd, ntm_pkg::IDLE_READ_VALUE)
    endtask : t_reset
    task automatic t_deliver();
        wait_st(ntm_pkg::OPST_DELIVERED);
        `CHK(r_ent !== 16'h0000, 1'b1)
        poll();
        `CHK(r_st, ntm_pkg::OPST_PENDING)
    endtask : t_deliver
    task automatic t_test();
        csr(1'b1, 2'h1, 32'h8000_0000);
        `CHK({r_ill, r_rd}, 33'h1_0000_0000)
        step();
        `CHK(test_mode, 1'b0)
        csr(1'b1, ntm_pkg::PRIV_MACHINE, 32'h8000_0000);
        step();
        `CHK(test_mode, 1'b1)
        for (int i = 0; i < 30; i++) begin
            poll();
            `CHK({r_st, r_ent}, {ntm_pkg::OPST_SELF_TEST, 16'h0000})
        end
        csr(1'b0, ntm_pkg::PRIV_MACHINE, 32'h0000_0000);
        // the enable bit and the zero bits 30:16 are checked, the raw samples below are left alone
        `CHK(r_rd[31:16], 16'h8000)
        csr(1'b1, ntm_pkg::PRIV_MACHINE, 32'h0000_0000);
        poll();
        `CHK(r_st, ntm_pkg::OPST_SELF_TEST)
        wait_st(ntm_pkg::OPST_DELIVERED);
    endtask : t_test
    task automatic t_alarm();
        stuck = 1'b1;
        repeat (12) step();
        // a source stuck past the cutoff must stay in self-test
        for (int i = 0; i < 10; i++) begin
            poll();
            `CHK(r_st, ntm_pkg::OPST_SELF_TEST)
        end
        stuck = 1'b0;
        wait_st(ntm_pkg::OPST_DELIVERED);
    endtask : t_alarm
    task automatic t_fatal();
        fatal = 1'b1;
        repeat (4) step();
        fatal = 1'b0;
        poll();
        `CHK(r_st, ntm_pkg::OPST_FATAL)
        csr(1'b1, ntm_pkg::PRIV_MACHINE, 32'h8000_0000);
        step();
        poll();
        `CHK(r_st, ntm_pkg::OPST_FATAL)
        arst_n = 1'b0;
        step();
        arst_n = 1'b1;
        step();
        `CHK({test_mode, opst}, 3'h0)
        csr(1'b0, ntm_pkg::PRIV_MACHINE, 32'h0000_0000);
        `CHK(r_rd, ntm_pkg::IDLE_READ_VALUE)
        // fatal state gone and health counters clean, so a word comes again
        wait_st(ntm_pkg::OPST_DELIVERED);
    endtask : t_fatal
    initial begin
        repeat (12) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_deliver();
        t_test();
        t_alarm();
        t_fatal();
        end_of_test();
    end
endmodule : ntm_noise_test_ctrl_test
